// ---- rte_ahb_regs.sv ----
// ahb-lite register slave of the receiver targeting evaluator
`timescale 1ns/1ps
`include "rte_defs.svh"

module rte_ahb_regs (
	// clock and reset
	input  wire logic               hclk,
	input  wire logic               hresetn,
	// ahb-lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// block state in
	input  wire logic [15:0]        status_in,
	input  wire logic               err_set,
	// configuration out
	output logic                    enable,
	output rte_pkg::rte_props_t     props
);

	logic        wr_pend_reg;  // write data phase pending
	logic [7:0]  wr_addr_reg;  // captured write offset
	logic        err_reg;      // sticky length error
	logic        addr_take;    // valid address phase

	assign addr_take = hsel && htrans[1] && hready;

	// ---------------------------------------------------------------
	// address phase capture
	// ---------------------------------------------------------------
	// no wait states; hsize is ignored since only words are used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= addr_take && hwrite;
			wr_addr_reg <= haddr[7:0];
		end
	end

	// ---------------------------------------------------------------
	// writable registers, written in the data phase
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable              <= `RTE_CTRL_RST;
			props.geo           <= `RTE_GEO_RST;
			props.demo          <= `RTE_DEMO_RST;
			props.postal        <= `RTE_POST_RST;
			props.postal_len_m1 <= `RTE_POST_LEN_RST;
		end else if (wr_pend_reg) begin
			unique case (wr_addr_reg)
				`RTE_OFF_CTRL:     enable              <= hwdata[0];
				`RTE_OFF_GEO:      props.geo           <= hwdata[23:0];
				`RTE_OFF_DEMO:     props.demo          <= hwdata[15:0];
				`RTE_OFF_POST_LO:  props.postal[31:0]  <= hwdata;
				`RTE_OFF_POST_HI:  props.postal[63:32] <= hwdata;
				`RTE_OFF_POST_LEN: props.postal_len_m1 <= hwdata[2:0];
				default: ; // unmapped or read-only: ignored
			endcase
		end
	end

	// sticky error; a new error wins over a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_reg <= 1'b0;
		end else if (err_set) begin
			err_reg <= 1'b1;
		end else if (wr_pend_reg && wr_addr_reg == `RTE_OFF_STATUS &&
		             hwdata[`RTE_ST_ERR]) begin
			err_reg <= 1'b0;
		end
	end

	// read data prepared in the address phase, shown in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_take && !hwrite) begin
			unique case (haddr[7:0])
				`RTE_OFF_CTRL:     hrdata <= {31'h0, enable};
				`RTE_OFF_STATUS:   hrdata <= {16'h0000, status_in[15:5],
				                              err_reg, status_in[3:0]};
				`RTE_OFF_GEO:      hrdata <= {8'h00, props.geo};
				`RTE_OFF_DEMO:     hrdata <= {16'h0000, props.demo};
				`RTE_OFF_POST_LO:  hrdata <= props.postal[31:0];
				`RTE_OFF_POST_HI:  hrdata <= props.postal[63:32];
				`RTE_OFF_POST_LEN: hrdata <= {29'h0, props.postal_len_m1};
				default:           hrdata <= 32'h00000000;
			endcase
		end
	end

endmodule : rte_ahb_regs

// ---- rte_defs.svh ----
// constants for the receiver targeting evaluator
`ifndef RTE_DEFS_SVH
`define RTE_DEFS_SVH

// descriptor format
`define RTE_TAG           8'hc7
`define RTE_TYPE_GEO      5'h01
`define RTE_TYPE_POSTAL   5'h02
`define RTE_TYPE_DEMO     5'h03
`define RTE_GEO_LEN_M1    3'h2
`define RTE_DEMO_LEN_M1   3'h1

// register byte offsets
`define RTE_OFF_CTRL      8'h00
`define RTE_OFF_STATUS    8'h04
`define RTE_OFF_GEO       8'h08
`define RTE_OFF_DEMO      8'h0c
`define RTE_OFF_POST_LO   8'h10
`define RTE_OFF_POST_HI   8'h14
`define RTE_OFF_POST_LEN  8'h18

// status field positions
`define RTE_ST_BUSY       0
`define RTE_ST_RESULT     1
`define RTE_ST_SVC        2
`define RTE_ST_ITEM       3
`define RTE_ST_ERR        4
`define RTE_ST_CNT_LO     8

// reset values
`define RTE_CTRL_RST      1'b1
`define RTE_GEO_RST       24'h000000
`define RTE_DEMO_RST      16'h0000
`define RTE_POST_RST      64'h0000000000000000
`define RTE_POST_LEN_RST  3'h4

`endif

// ---- rte_demux_model.sv ----
// section demultiplexer model that feeds descriptor bytes
`timescale 1ns/1ps

module rte_demux_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// pacing: one idle cycle after every byte taken
	input  wire logic       slow,
	// byte stream towards the evaluator
	input  wire logic       in_ready,
	output logic            in_valid,
	output logic [7:0]      in_byte
);
	logic [7:0] fifo_q[$]; // bytes waiting to be sent
	logic       stall;     // idle cycle in slow mode

	// queue one byte, whole bytes only, msb first on the line
	task automatic push(input logic [7:0] b);
		fifo_q.push_back(b);
	endtask : push

	// -----------------------------------------------------------
	// byte handshake
	// -----------------------------------------------------------
	// a byte is held until taken; an idle line shows a changing
	// pattern so a parser that reads it without valid goes wrong
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_valid <= 1'b0;
			in_byte  <= 8'h00;
		end else begin
			stall = slow && in_valid && in_ready;
			if (in_valid && in_ready)
				void'(fifo_q.pop_front());
			if (fifo_q.size() != 0 && !stall) begin
				in_valid <= 1'b1;
				in_byte  <= fifo_q[0];
			end else begin
				in_valid <= 1'b0;
				in_byte  <= ~in_byte;
			end
		end
	end
endmodule : rte_demux_model

// ---- rte_evaluator.sv ----
// receiver targeting descriptor parser and evaluator, top level
`timescale 1ns/1ps
`include "rte_defs.svh"

module rte_evaluator (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// descriptor bytes from the section demultiplexer
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_byte,
	output logic             in_ready,
	input  wire logic        loop_start,
	input  wire logic        loop_is_item,
	// targeting results
	output logic             desc_done,
	output logic             desc_result,
	output logic             svc_targeted,
	output logic             item_targeted
);

	rte_pkg::rte_state_t st_reg;      // parser state
	rte_pkg::rte_props_t props;       // receiver properties
	rte_pkg::rte_entry_t entry;       // entry under evaluation
	logic        enable;              // byte intake enabled
	logic        take;                // byte accepted this cycle
	logic        tag_ok_reg;          // descriptor is a targeting one
	logic [7:0]  rem_reg;             // bytes left before end
	logic [7:0]  ents_reg;            // entries left
	logic [2:0]  vcnt_reg;            // value bytes left minus one
	logic [4:0]  ctype_reg;           // type of current entry
	logic [2:0]  len_reg;             // length field of current entry
	logic [63:0] val_reg;             // value assembled so far
	logic [63:0] val_next;            // value with this byte added
	logic [2:0]  seen_reg, seen_next; // criteria present
	logic [2:0]  hit_reg, hit_next;   // criteria with a true term
	logic        bad_reg, bad_next;   // unknown criterion present
	logic        term, known;         // verdict on the entry
	logic        last_val;            // final value byte of an entry
	logic        end_now;             // descriptor ends with this byte
	logic        err_now;             // descriptor truncated by length
	logic        final_ok;            // descriptor result
	logic        scope_item_reg;      // current loop is item level
	logic        svc_acc_reg;         // AND of service descriptors
	logic        item_acc_reg;        // AND of item descriptors
	logic [7:0]  cnt_reg;             // descriptors evaluated
	logic [15:0] status;              // status word for software

	assign take     = in_valid && in_ready;
	assign val_next = {val_reg[55:0], in_byte};
	assign last_val = take && st_reg == rte_pkg::ST_VALUE &&
	                  vcnt_reg == 3'h0;

	// ---------------------------------------------------------------
	// register slave and entry comparison
	// ---------------------------------------------------------------
	rte_ahb_regs u_regs (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.status_in (status),
		.err_set   (err_now),
		.enable    (enable),
		.props     (props)
	);

	assign entry.ctype  = ctype_reg;
	assign entry.len_m1 = len_reg;
	assign entry.value  = val_next;

	rte_term_match u_match (
		.entry (entry),
		.props (props),
		.term  (term),
		.known (known)
	);

	assign status = {cnt_reg, 3'h0, 1'b0, item_targeted, svc_targeted,
	                 desc_result, st_reg != rte_pkg::ST_TAG};

	// ---------------------------------------------------------------
	// end and error detection for the byte just taken
	// ---------------------------------------------------------------
	// the length byte bounds everything; running out of it mid-entry
	// is an error and ends the descriptor there
	always_comb begin
		end_now = 1'b0;
		err_now = 1'b0;
		if (take) begin
			unique case (st_reg)
				rte_pkg::ST_TAG: ;
				rte_pkg::ST_LEN: begin
					end_now = (in_byte == 8'h00);
					err_now = (in_byte == 8'h00) && tag_ok_reg;
				end
				rte_pkg::ST_COUNT: begin
					end_now = (rem_reg == 8'h01);
					err_now = (rem_reg == 8'h01) && (in_byte != 8'h00);
				end
				rte_pkg::ST_HDR: begin
					end_now = (rem_reg == 8'h01);
					err_now = (rem_reg == 8'h01);
				end
				rte_pkg::ST_VALUE: begin
					end_now = (rem_reg == 8'h01);
					err_now = (rem_reg == 8'h01) &&
					          !(last_val && ents_reg == 8'h01);
				end
				rte_pkg::ST_TAIL, rte_pkg::ST_SKIP: begin
					end_now = (rem_reg == 8'h01);
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// term combination
	// ---------------------------------------------------------------
	// one bit per supported criterion; an unknown criterion can never
	// be matched here, so its presence forces a false result
	always_comb begin
		seen_next = seen_reg;
		hit_next  = hit_reg;
		bad_next  = bad_reg;
		if (last_val) begin
			if (known) begin
				seen_next[ctype_reg[1:0] - 2'h1] = 1'b1;
				hit_next[ctype_reg[1:0] - 2'h1]  =
					hit_reg[ctype_reg[1:0] - 2'h1] | term;
			end else begin
				bad_next = 1'b1;
			end
		end
		final_ok = !bad_next && !err_now &&
		           (&(~seen_next | hit_next));
	end

	// ---------------------------------------------------------------
	// parser state
	// ---------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg <= rte_pkg::ST_TAG;
		end else if (take) begin
			if (end_now) begin
				st_reg <= rte_pkg::ST_TAG;
			end else begin
				unique case (st_reg)
					rte_pkg::ST_TAG:   st_reg <= rte_pkg::ST_LEN;
					rte_pkg::ST_LEN:   st_reg <= tag_ok_reg ?
					                   rte_pkg::ST_COUNT : rte_pkg::ST_SKIP;
					rte_pkg::ST_COUNT: st_reg <= (in_byte == 8'h00) ?
					                   rte_pkg::ST_TAIL : rte_pkg::ST_HDR;
					rte_pkg::ST_HDR:   st_reg <= rte_pkg::ST_VALUE;
					rte_pkg::ST_VALUE: begin
						if (last_val) begin
							st_reg <= (ents_reg == 8'h01) ?
							          rte_pkg::ST_TAIL : rte_pkg::ST_HDR;
						end
					end
					rte_pkg::ST_TAIL:  ;
					rte_pkg::ST_SKIP:  ;
				endcase
			end
		end
	end

	// tag check; any other descriptor is skipped by its length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tag_ok_reg <= 1'b0;
		end else if (take && st_reg == rte_pkg::ST_TAG) begin
			tag_ok_reg <= (in_byte == `RTE_TAG);
		end
	end

	// remaining length, loaded from the length byte
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rem_reg <= 8'h00;
		end else if (take && st_reg == rte_pkg::ST_LEN) begin
			rem_reg <= in_byte;
		end else if (take && st_reg != rte_pkg::ST_TAG) begin
			rem_reg <= rem_reg - 8'h01;
		end
	end

	// entry counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ents_reg <= 8'h00;
		end else if (take && st_reg == rte_pkg::ST_COUNT) begin
			ents_reg <= in_byte;
		end else if (last_val) begin
			ents_reg <= ents_reg - 8'h01;
		end
	end

	// entry header split and value assembly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctype_reg <= 5'h00;
			len_reg   <= 3'h0;
			vcnt_reg  <= 3'h0;
			val_reg   <= 64'h0000000000000000;
		end else if (take && st_reg == rte_pkg::ST_HDR) begin
			ctype_reg <= in_byte[7:3];
			len_reg   <= in_byte[2:0];
			vcnt_reg  <= in_byte[2:0];
			val_reg   <= 64'h0000000000000000;
		end else if (take && st_reg == rte_pkg::ST_VALUE) begin
			vcnt_reg  <= vcnt_reg - 3'h1;
			val_reg   <= val_next;
		end
	end

	// per-descriptor accumulators, cleared at each descriptor end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen_reg <= 3'h0;
			hit_reg  <= 3'h0;
			bad_reg  <= 1'b0;
		end else if (end_now) begin
			seen_reg <= 3'h0;
			hit_reg  <= 3'h0;
			bad_reg  <= 1'b0;
		end else begin
			seen_reg <= seen_next;
			hit_reg  <= hit_next;
			bad_reg  <= bad_next;
		end
	end

	// ---------------------------------------------------------------
	// loop level results
	// ---------------------------------------------------------------
	// several descriptors in one loop all have to pass; a new service
	// loop also restarts the item result, since items belong to it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			scope_item_reg <= 1'b0;
			svc_acc_reg    <= 1'b1;
			item_acc_reg   <= 1'b1;
		end else if (loop_start) begin
			scope_item_reg <= loop_is_item;
			item_acc_reg   <= 1'b1;
			if (!loop_is_item) begin
				svc_acc_reg <= 1'b1;
			end
		end else if (end_now && tag_ok_reg) begin
			if (scope_item_reg) begin
				item_acc_reg <= item_acc_reg & final_ok;
			end else begin
				svc_acc_reg  <= svc_acc_reg & final_ok;
			end
		end
	end

	// registered outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			in_ready      <= 1'b0;
			desc_done     <= 1'b0;
			desc_result   <= 1'b0;
			svc_targeted  <= 1'b1;
			item_targeted <= 1'b1;
			cnt_reg       <= 8'h00;
		end else begin
			in_ready      <= enable;
			desc_done     <= end_now && tag_ok_reg;
			svc_targeted  <= svc_acc_reg;
			item_targeted <= svc_acc_reg & item_acc_reg;
			if (end_now && tag_ok_reg) begin
				desc_result <= final_ok;
				cnt_reg     <= cnt_reg + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	sequence s_hdr_taken;
		take && st_reg == rte_pkg::ST_HDR && rem_reg > 8'h01;
	endsequence

	sequence s_last_byte;
		take && tag_ok_reg && st_reg != rte_pkg::ST_TAG &&
		st_reg != rte_pkg::ST_LEN && rem_reg == 8'h01;
	endsequence

	a_tag_gates_parse: assert property (@(posedge hclk) disable iff (!hresetn)
		take && st_reg == rte_pkg::ST_LEN && tag_ok_reg == 1'b0 &&
		in_byte != 8'h00 |=> st_reg == rte_pkg::ST_SKIP)
		else $error("foreign descriptor not skipped");

	a_length_ends_desc: assert property (@(posedge hclk) disable iff (!hresetn)
		s_last_byte |=> desc_done ##1 !desc_done)
		else $error("descriptor end not flagged once");

	a_count_loaded: assert property (@(posedge hclk) disable iff (!hresetn)
		take && st_reg == rte_pkg::ST_COUNT && rem_reg > 8'h01 |=>
		ents_reg == $past(in_byte))
		else $error("entry count not loaded");

	a_header_split: assert property (@(posedge hclk) disable iff (!hresetn)
		s_hdr_taken |=> st_reg == rte_pkg::ST_VALUE &&
		ctype_reg == $past(in_byte[7:3]) && vcnt_reg == $past(in_byte[2:0]))
		else $error("entry header split wrong");

	a_value_msb_first: assert property (@(posedge hclk) disable iff (!hresetn)
		take && st_reg == rte_pkg::ST_VALUE |=>
		val_reg[7:0] == $past(in_byte) &&
		val_reg[15:8] == $past(val_reg[7:0]))
		else $error("value not shifted in msb first");

	a_unknown_false: assert property (@(posedge hclk) disable iff (!hresetn)
		end_now && tag_ok_reg && bad_next |=> !desc_result)
		else $error("unknown criterion gave true result");

	a_and_of_criteria: assert property (@(posedge hclk) disable iff (!hresetn)
		end_now && tag_ok_reg && !err_now && !bad_next &&
		seen_next == hit_next |=> desc_result)
		else $error("all criteria matched but result false");

	a_item_needs_svc: assert property (@(posedge hclk) disable iff (!hresetn)
		item_targeted |-> svc_targeted)
		else $error("item targeted while service is not");

	a_svc_result_kept: assert property (@(posedge hclk) disable iff (!hresetn)
		end_now && tag_ok_reg && !scope_item_reg && !loop_start &&
		!final_ok |=> ##1 !svc_targeted)
		else $error("failed service descriptor not applied");

endmodule : rte_evaluator

// ---- rte_pkg.sv ----
// types shared by the receiver targeting evaluator
package rte_pkg;

	// parser states
	typedef enum logic [2:0] {
		ST_TAG, ST_LEN, ST_COUNT, ST_HDR, ST_VALUE, ST_TAIL, ST_SKIP
	} rte_state_t;

	// receiver-held property values
	typedef struct packed {
		logic [23:0] geo;           // low three bytes of location code
		logic [15:0] demo;          // low two bytes of category code
		logic [63:0] postal;        // right-justified postal code
		logic [2:0]  postal_len_m1; // postal code bytes minus one
	} rte_props_t;

	// one parsed entry
	typedef struct packed {
		logic [4:0]  ctype;  // criterion type code
		logic [2:0]  len_m1; // value bytes minus one
		logic [63:0] value;  // right-justified value
	} rte_entry_t;

endpackage : rte_pkg

// ---- rte_term_match.sv ----
// one entry compared against the receiver properties
`timescale 1ns/1ps
`include "rte_defs.svh"

module rte_term_match (
	// parsed entry
	input  wire rte_pkg::rte_entry_t entry,
	// receiver properties
	input  wire rte_pkg::rte_props_t props,
	// verdict
	output logic                     term,
	output logic                     known
);

	// compare by type; a wrong length can never match
	always_comb begin
		term  = 1'b0;
		known = 1'b1;
		unique case (entry.ctype)
			`RTE_TYPE_GEO: begin
				term = (entry.len_m1 == `RTE_GEO_LEN_M1) &&
				       (entry.value == {40'h0000000000, props.geo});
			end
			`RTE_TYPE_POSTAL: begin
				term = (entry.len_m1 == props.postal_len_m1) &&
				       (entry.value == props.postal);
			end
			`RTE_TYPE_DEMO: begin
				term = (entry.len_m1 == `RTE_DEMO_LEN_M1) &&
				       (entry.value == {48'h000000000000, props.demo});
			end
			// reserved and private codes give a false term
			default: begin
				known = 1'b0;
			end
		endcase
	end

endmodule : rte_term_match

// ---- tb_top.sv ----
// self-checking testbench of the receiver targeting evaluator
`timescale 1ns/1ps
`include "rte_defs.svh"

module tb_top;
	// -----------------------------------------------------------
	// signals
	// -----------------------------------------------------------
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        in_valid, in_ready, loop_start, loop_is_item, slow;
	logic [7:0]  in_byte;
	logic        desc_done, desc_result, svc_targeted, item_targeted;
	int          mismatches  = 0;
	int          checks_done = 0;

	// descriptors, right-justified, with byte counts and verdicts
	localparam int ND = 9;
	logic [111:0] dv [ND] = '{
		112'hc7_05_01_0a_12_34_56,
		112'hc7_0c_03_0a_11_11_11_0a_12_34_56_19_00_77,
		112'hc7_08_02_0a_12_34_56_19_00_66,
		112'hc7_07_01_14_39_34_30_34_33,
		112'hc7_07_02_28_00_0a_12_34_56,
		112'hc7_03_01_80_ff,
		112'hc7_07_01_0a_12_34_56_ee_ee,
		112'hc7_01_00,
		112'hc7_03_01_0a_12};
	int   dn [ND] = '{7, 14, 10, 9, 9, 5, 9, 3, 5};
	logic de [ND] = '{1, 1, 0, 1, 0, 0, 1, 1, 0};

	// -----------------------------------------------------------
	// design and far side
	// -----------------------------------------------------------
	rte_evaluator rte_evaluator_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.in_valid(in_valid), .in_byte(in_byte), .in_ready(in_ready),
		.loop_start(loop_start), .loop_is_item(loop_is_item),
		.desc_done(desc_done), .desc_result(desc_result),
		.svc_targeted(svc_targeted), .item_targeted(item_targeted));
	rte_demux_model dm_inst (.hclk(hclk), .hresetn(hresetn),
		.slow(slow), .in_ready(in_ready), .in_valid(in_valid),
		.in_byte(in_byte));

	// 25 MHz clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	// -----------------------------------------------------------
	// tasks
	// -----------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one single ahb-lite transfer; waits on hready, giving up after 64 cycles per phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= wd;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 64);
		rd = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h00000000, r);
		chk(r, e);
		chk(32'(hresp), 32'h00000000);
	endtask : rd_chk

	// pulse loop_start between descriptors only
	task automatic start_loop(input logic item);
		loop_start <= 1'b1;
		loop_is_item <= item;
		@(posedge hclk);
		loop_start <= 1'b0;
		@(posedge hclk);
	endtask : start_loop

	task automatic push_desc(input logic [111:0] d, input int n);
		for (int i = 0; i < n; i++) dm_inst.push(d[8*(n-1-i) +: 8]);
	endtask : push_desc

	// wait for the end pulse, check the verdict, let flags settle
	task automatic wait_done(input logic exp);
		int n;
		n = 0;
		do begin @(posedge hclk); n++; end while (desc_done !== 1'b1 && n < 400);
		chk(32'(desc_done), 32'h00000001);
		chk(32'(desc_result), 32'(exp));
		@(posedge hclk);
	endtask : wait_done

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	// hang guard, far above the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge hclk);
		mismatches++;
		summarize();
	end

	// -----------------------------------------------------------
	// test sequence
	// -----------------------------------------------------------
	initial begin
		hresetn <= 1'b0;
		{hsel, hwrite, loop_start, loop_is_item, slow} <= 5'h00;
		haddr <= 32'h00000000;
		hwdata <= 32'h00000000;
		htrans <= 2'b00;
		hsize <= 3'h2;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values, then an unmapped place
		rd_chk(`RTE_OFF_CTRL, 32'h00000001);
		rd_chk(`RTE_OFF_STATUS, 32'h0000000c);
		rd_chk(`RTE_OFF_POST_LEN, 32'h00000004);
		rd_chk(`RTE_OFF_GEO, 32'h00000000);
		rd_chk(8'h1c, 32'h00000000);
		// receiver properties
		wr(`RTE_OFF_GEO, 32'h00123456);
		wr(`RTE_OFF_DEMO, 32'h00000077);
		wr(`RTE_OFF_POST_LO, 32'h34303433);
		wr(`RTE_OFF_POST_HI, 32'h00000039);
		rd_chk(`RTE_OFF_GEO, 32'h00123456);
		// each descriptor alone in a service loop
		for (int k = 0; k < ND; k++) begin
			start_loop(1'b0);
			push_desc(dv[k], dn[k]);
			wait_done(de[k]);
			chk(32'(svc_targeted), 32'(de[k]));
			chk(32'(item_targeted), 32'(de[k]));
		end
		// nine ended, last one cut short: sticky error, then cleared
		rd_chk(`RTE_OFF_STATUS, 32'h00000910);
		wr(`RTE_OFF_STATUS, 32'h00000010);
		rd_chk(`RTE_OFF_STATUS, 32'h00000900);
		// a foreign tag is skipped without an end pulse
		start_loop(1'b0);
		push_desc(112'hca_02_aa_bb, 4);
		push_desc(dv[0], dn[0]);
		wait_done(1'b1);
		// bytes are not taken while disabled
		wr(`RTE_OFF_CTRL, 32'h00000000);
		repeat (2) @(posedge hclk);
		push_desc(dv[2], dn[2]);
		repeat (4) @(posedge hclk);
		chk(32'(in_ready), 32'h00000000);
		chk(32'(dm_inst.fifo_q.size()), 32'd10);
		wr(`RTE_OFF_CTRL, 32'h00000001);
		wait_done(1'b0);
		// service result covers items, item result one item only
		slow <= 1'b1;
		start_loop(1'b0);
		push_desc(dv[0], dn[0]);
		wait_done(1'b1);
		start_loop(1'b1);
		push_desc(dv[2], dn[2]);
		wait_done(1'b0);
		chk(32'(svc_targeted), 32'h00000001);
		chk(32'(item_targeted), 32'h00000000);
		start_loop(1'b1);
		push_desc(dv[0], dn[0]);
		wait_done(1'b1);
		chk(32'(item_targeted), 32'h00000001);
		start_loop(1'b0);
		push_desc(dv[2], dn[2]);
		wait_done(1'b0);
		chk(32'(svc_targeted), 32'h00000000);
		chk(32'(item_targeted), 32'h00000000);
		rd_chk(`RTE_OFF_STATUS, 32'h00000f00);
		summarize();
	end
endmodule : tb_top
